// >>> core/ring_mon_pkg.sv
// Shared types and constants of the ring link integrity monitor
package ring_mon_pkg;
    localparam int NCH = 2;
    localparam int CNT_W = 16;
    localparam int BITS_W = 112;
    localparam int PAY_W = 128;
    // Integrity check, 32-bit, MSB first
    localparam logic [31:0] CRC_POLY = 32'h04c11db7;
    localparam logic [31:0] CRC_INIT = 32'hffffffff;
    // Clock and message timing
    localparam int CLK_KHZ = 200000;
    localparam int INTEG_MS_64 = 500;
    localparam int INTEG_MS_128 = 250;
    localparam int RET_MS = 20;
    // Register byte addresses
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_OUTS = 8'h04;
    localparam logic [7:0] A_STAT = 8'h08;
    localparam logic [7:0] A_IRQ_ST = 8'h0c;
    localparam logic [7:0] A_IRQ_MASK = 8'h10;
    // Per-channel block: region 2'h1, channel select bit, word offset
    localparam logic [1:0] CH_REGION = 2'h1;
    localparam int CH_SEL_BIT = 5;
    localparam logic [4:0] C_CRC_CFG = 5'h00;
    localparam logic [4:0] C_LOST_CFG = 5'h04;
    localparam logic [4:0] C_CRC_CNT = 5'h08;
    localparam logic [4:0] C_LOST_CNT = 5'h0c;
    localparam logic [4:0] C_CRC_TOT = 5'h10;
    localparam logic [4:0] C_LOST_TOT = 5'h14;
    // Control register fields
    localparam int F_PROG = 0;
    localparam int F_RING = 1;
    localparam int F_RATE = 2;
    localparam int F_ID_LO = 8;
    localparam int F_ID_HI = 15;
    // Interrupt bits
    localparam int IRQ_W = 5;
    localparam int I_CRC = 0;
    localparam int I_LOST = 2;
    localparam int I_BREAK = 4;
    // Reset values of thresholds and windows
    localparam logic [15:0] CRC_THR_RST = 16'h000a;
    localparam logic [15:0] CRC_WIN_RST = 16'h04b0;
    localparam logic [15:0] LOST_THR_RST = 16'h000a;
    localparam logic [15:0] LOST_WIN_RST = 16'h04b0;

    typedef struct packed {
        logic [7:0] origin;
        logic [7:0] seq;
        logic [BITS_W-1:0] bits;
        logic [31:0] crc;
    } msg_s;

    typedef struct packed {
        logic [CNT_W-1:0] tot;
        logic [CNT_W-1:0] bad;
        logic alarm;
    } mon_s;

    typedef struct packed {
        logic [CNT_W-1:0] crc_fail_threshold;
        logic [CNT_W-1:0] crc_window_length;
        logic [CNT_W-1:0] lost_msg_threshold;
        logic [CNT_W-1:0] lost_msg_window_length;
        mon_s crc;
        mon_s lost;
        logic [CNT_W-1:0] crc_fail_total;
        logic [CNT_W-1:0] lost_msg_total;
        logic wait_ret;
        logic [7:0] ret_seq;
        logic [31:0] ret_tmr;
    } chan_s;
endpackage

// >>> core/ring_link_integrity_monitor.sv
// Ring link integrity monitor: checks, counts, alarms and integrity sends
//
// Function
// - Check each received message with 32-bit CRC
// - Count every received message, failed ones too
// - Separate counter of failed-check messages
// - Fail count reaching threshold sets check alarm
// - Window count reached clears both monitor counters
// - Check monitor independent per channel
// - Readable cumulative failed-check total per channel
// - Integrity sends: 2/s at 64k, 4/s at 128k
// - Count every originated message per channel
// - Originated message must return within set period
// - Count originated messages that never returned
// - Lost count reaching threshold sets lost alarm
// - Lost monitor per channel, ring mode only
// - Readable cumulative lost-message total per channel
// - Relay outputs inhibited until programmed
// - Unprogrammed by default, self-test error shown
// - Forward messages that others originated
// - Unreturned message in ring raises ring break
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module ring_link_integrity_monitor #(
    parameter int unsigned INTEG_CYC_64 =
        ring_mon_pkg::INTEG_MS_64 * ring_mon_pkg::CLK_KHZ,
    parameter int unsigned INTEG_CYC_128 =
        ring_mon_pkg::INTEG_MS_128 * ring_mon_pkg::CLK_KHZ,
    parameter int unsigned RET_CYC =
        ring_mon_pkg::RET_MS * ring_mon_pkg::CLK_KHZ
) (
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wen_i,
    input wire logic ren_i,
    output logic [31:0] rdata_o,
    input wire logic [ring_mon_pkg::NCH-1:0] rx_valid_i,
    input wire ring_mon_pkg::msg_s [ring_mon_pkg::NCH-1:0] rx_msg_i,
    output logic [ring_mon_pkg::NCH-1:0] tx_valid_o,
    output ring_mon_pkg::msg_s [ring_mon_pkg::NCH-1:0] tx_msg_o,
    output logic [15:0] relay_o,
    output logic unprog_o,
    output logic ring_break_o,
    output logic [ring_mon_pkg::NCH-1:0] crc_rate_alarm_flag_o,
    output logic [ring_mon_pkg::NCH-1:0] lost_msg_alarm_flag_o,
    output logic irq_o
);
    localparam int NCH = ring_mon_pkg::NCH;
    typedef struct packed {
        logic programmed;
        logic ring_mode;
        logic rate_hi;
        logic [7:0] own_id;
        logic [15:0] out_bits;
        logic [15:0] relay;
        logic unprog;
        logic ring_break;
        logic [31:0] integ_tmr;
        logic [7:0] seq;
        logic orig_pend;
        ring_mon_pkg::chan_s [NCH-1:0] ch;
        logic [NCH-1:0] tx_valid;
        ring_mon_pkg::msg_s [NCH-1:0] tx_msg;
        logic [ring_mon_pkg::IRQ_W-1:0] irq_stat;
        logic [ring_mon_pkg::IRQ_W-1:0] irq_mask;
        logic irq;
        logic [31:0] rdata;
    } state_s;

    state_s st;
    state_s next_st;
    logic [NCH-1:0] crc_ok;
    logic [NCH-1:0] fwd;
    logic orig;
    logic [NCH-1:0] lost_ev;
    ring_mon_pkg::msg_s omsg;
    // Bitwise CRC over the message payload
    function automatic logic [31:0] crc32(
        input logic [ring_mon_pkg::PAY_W-1:0] d);
        logic [31:0] c;
        c = ring_mon_pkg::CRC_INIT;
        for (int i = ring_mon_pkg::PAY_W - 1; i >= 0; i--) begin
            c = {c[30:0], 1'b0}
                ^ ((c[31] ^ d[i]) ? ring_mon_pkg::CRC_POLY : 32'h0);
        end
        return c;
    endfunction

    // One step of a windowed monitor: total, failures and alarm
    function automatic ring_mon_pkg::mon_s mon_step(
        input ring_mon_pkg::mon_s m, input logic [15:0] thr,
        input logic [15:0] win, input logic ev_tot, input logic ev_bad);
        ring_mon_pkg::mon_s r;
        r = m;
        r.tot = m.tot + {15'h0000, ev_tot};
        r.bad = m.bad + {15'h0000, ev_bad};
        if (ev_bad && thr != 16'h0000 && r.bad >= thr) begin
            r.alarm = 1'b1;
        end
        if (ev_tot && win != 16'h0000 && r.tot >= win) begin
            r = '0;
        end
        return r;
    endfunction

    // Per-channel integrity check of the received message
    for (genvar g = 0; g < NCH; g++) begin : g_chk
        assign crc_ok[g] = crc32({rx_msg_i[g].origin, rx_msg_i[g].seq,
            rx_msg_i[g].bits}) == rx_msg_i[g].crc;
    end

    // Originated message built from the current output state
    always_comb begin
        omsg.origin = st.own_id;
        omsg.seq = st.seq;
        omsg.bits = {{(ring_mon_pkg::BITS_W - 16){1'b0}}, st.out_bits};
        omsg.crc = crc32({omsg.origin, omsg.seq, omsg.bits});
    end

    // Next-state logic: register port, monitors, transmit and interrupts
    always_comb begin
        logic ci;
        logic ret;
        logic [ring_mon_pkg::IRQ_W-1:0] ev;
        ci = addr_i[ring_mon_pkg::CH_SEL_BIT];
        ret = 1'b0;
        ev = '0;
        next_st = st;
        next_st.rdata = 32'h0;
        next_st.tx_valid = '0;
        lost_ev = '0;
        // Forwarding takes the link first; origination waits until no channel forwards
        for (int c = 0; c < NCH; c++) begin
            fwd[c] = rx_valid_i[c] && crc_ok[c]
                && rx_msg_i[c].origin != st.own_id;
        end
        orig = st.orig_pend && fwd == '0;
        // Register writes
        if (wen_i) begin
            case (addr_i)
                ring_mon_pkg::A_CTRL: begin
                    next_st.programmed = wdata_i[ring_mon_pkg::F_PROG];
                    next_st.ring_mode = wdata_i[ring_mon_pkg::F_RING];
                    next_st.rate_hi = wdata_i[ring_mon_pkg::F_RATE];
                    next_st.own_id =
                        wdata_i[ring_mon_pkg::F_ID_HI:ring_mon_pkg::F_ID_LO];
                end
                ring_mon_pkg::A_OUTS: begin
                    if (wdata_i[15:0] != st.out_bits) begin
                        next_st.orig_pend = 1'b1;
                    end
                    next_st.out_bits = wdata_i[15:0];
                end
                ring_mon_pkg::A_IRQ_ST: begin
                    next_st.irq_stat =
                        st.irq_stat & ~wdata_i[ring_mon_pkg::IRQ_W-1:0];
                end
                ring_mon_pkg::A_IRQ_MASK: begin
                    next_st.irq_mask = wdata_i[ring_mon_pkg::IRQ_W-1:0];
                end
                default: begin
                    if (addr_i[7:6] == ring_mon_pkg::CH_REGION) begin
                        case (addr_i[4:0])
                            ring_mon_pkg::C_CRC_CFG: begin
                                next_st.ch[ci].crc_fail_threshold =
                                    wdata_i[15:0];
                                next_st.ch[ci].crc_window_length =
                                    wdata_i[31:16];
                            end
                            ring_mon_pkg::C_LOST_CFG: begin
                                next_st.ch[ci].lost_msg_threshold =
                                    wdata_i[15:0];
                                next_st.ch[ci].lost_msg_window_length =
                                    wdata_i[31:16];
                            end
                            default: ;
                        endcase
                    end
                end
            endcase
        end
        // Integrity send timer, period chosen by link rate
        if (st.integ_tmr == 32'h0) begin
            next_st.orig_pend = 1'b1;
        end else begin
            next_st.integ_tmr = st.integ_tmr - 32'h1;
        end
        if (orig) begin
            next_st.orig_pend = 1'b0;
            next_st.seq = st.seq + 8'h01;
            next_st.integ_tmr = st.rate_hi ? 32'(INTEG_CYC_128 - 1)
                : 32'(INTEG_CYC_64 - 1);
        end
        // Channel monitors
        for (int c = 0; c < NCH; c++) begin
            if (fwd[c]) begin
                next_st.tx_valid[c] = 1'b1;
                next_st.tx_msg[c] = rx_msg_i[c];
            end else if (orig) begin
                next_st.tx_valid[c] = 1'b1;
                next_st.tx_msg[c] = omsg;
            end
            next_st.ch[c].crc = mon_step(st.ch[c].crc,
                st.ch[c].crc_fail_threshold, st.ch[c].crc_window_length,
                rx_valid_i[c], rx_valid_i[c] && !crc_ok[c]);
            if (rx_valid_i[c] && !crc_ok[c]) begin
                next_st.ch[c].crc_fail_total =
                    st.ch[c].crc_fail_total + 16'h0001;
            end
            ret = rx_valid_i[c] && crc_ok[c] && st.ch[c].wait_ret
                && rx_msg_i[c].origin == st.own_id
                && rx_msg_i[c].seq == st.ch[c].ret_seq;
            // Lost when the wait expires or a newer message replaces it
            lost_ev[c] = st.ring_mode && st.ch[c].wait_ret && !ret
                && (st.ch[c].ret_tmr == 32'h0 || orig);
            if (st.ch[c].wait_ret && st.ch[c].ret_tmr != 32'h0) begin
                next_st.ch[c].ret_tmr = st.ch[c].ret_tmr - 32'h1;
            end
            if (ret || lost_ev[c]) begin
                next_st.ch[c].wait_ret = 1'b0;
            end
            if (ret) begin
                next_st.ring_break = 1'b0;
            end
            if (st.ring_mode && orig) begin
                next_st.ch[c].wait_ret = 1'b1;
                next_st.ch[c].ret_seq = st.seq;
                next_st.ch[c].ret_tmr = 32'(RET_CYC - 1);
            end
            next_st.ch[c].lost = mon_step(st.ch[c].lost,
                st.ch[c].lost_msg_threshold,
                st.ch[c].lost_msg_window_length,
                orig, lost_ev[c]);
            if (lost_ev[c]) begin
                next_st.ch[c].lost_msg_total =
                    st.ch[c].lost_msg_total + 16'h0001;
            end
            if (!st.ring_mode) begin
                next_st.ch[c].wait_ret = 1'b0;
                next_st.ch[c].lost.alarm = 1'b0;
            end
            ev[ring_mon_pkg::I_CRC + c] =
                next_st.ch[c].crc.alarm && !st.ch[c].crc.alarm;
            ev[ring_mon_pkg::I_LOST + c] =
                next_st.ch[c].lost.alarm && !st.ch[c].lost.alarm;
        end
        // Ring break set wins over a return seen in the same cycle
        if (lost_ev != '0) begin
            next_st.ring_break = 1'b1;
        end
        if (!st.ring_mode) begin
            next_st.ring_break = 1'b0;
        end
        ev[ring_mon_pkg::I_BREAK] = next_st.ring_break && !st.ring_break;
        // Sticky status: a new event beats a same-cycle clear
        next_st.irq_stat = next_st.irq_stat | ev;
        next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
        // Relay outputs stay off until the settings are programmed
        next_st.unprog = !next_st.programmed;
        next_st.relay = next_st.programmed ? next_st.out_bits
            : 16'h0000;
        // Register reads, data valid the cycle after the strobe
        if (ren_i) begin
            case (addr_i)
                ring_mon_pkg::A_CTRL: begin
                    next_st.rdata[ring_mon_pkg::F_PROG] = st.programmed;
                    next_st.rdata[ring_mon_pkg::F_RING] = st.ring_mode;
                    next_st.rdata[ring_mon_pkg::F_RATE] = st.rate_hi;
                    next_st.rdata[ring_mon_pkg::F_ID_HI:
                        ring_mon_pkg::F_ID_LO] = st.own_id;
                end
                ring_mon_pkg::A_OUTS: next_st.rdata[15:0] = st.out_bits;
                ring_mon_pkg::A_STAT: begin
                    for (int c = 0; c < NCH; c++) begin
                        next_st.rdata[c] = st.ch[c].crc.alarm;
                        next_st.rdata[NCH + c] = st.ch[c].lost.alarm;
                    end
                    next_st.rdata[2 * NCH] = st.ring_break;
                    next_st.rdata[2 * NCH + 1] = st.unprog;
                end
                ring_mon_pkg::A_IRQ_ST: begin
                    next_st.rdata[ring_mon_pkg::IRQ_W-1:0] = st.irq_stat;
                end
                ring_mon_pkg::A_IRQ_MASK: begin
                    next_st.rdata[ring_mon_pkg::IRQ_W-1:0] = st.irq_mask;
                end
                default: begin
                    if (addr_i[7:6] == ring_mon_pkg::CH_REGION) begin
                        case (addr_i[4:0])
                            ring_mon_pkg::C_CRC_CFG: next_st.rdata = {
                                st.ch[ci].crc_window_length,
                                st.ch[ci].crc_fail_threshold};
                            ring_mon_pkg::C_LOST_CFG: next_st.rdata = {
                                st.ch[ci].lost_msg_window_length,
                                st.ch[ci].lost_msg_threshold};
                            ring_mon_pkg::C_CRC_CNT: next_st.rdata = {
                                st.ch[ci].crc.bad, st.ch[ci].crc.tot};
                            ring_mon_pkg::C_LOST_CNT: next_st.rdata = {
                                st.ch[ci].lost.bad, st.ch[ci].lost.tot};
                            ring_mon_pkg::C_CRC_TOT: next_st.rdata[15:0] =
                                st.ch[ci].crc_fail_total;
                            ring_mon_pkg::C_LOST_TOT: next_st.rdata[15:0] =
                                st.ch[ci].lost_msg_total;
                            default: next_st.rdata = 32'h0;
                        endcase
                    end
                end
            endcase
        end
    end

    // State register with reset defaults
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            st <= '0;
            st.unprog <= 1'b1;
            for (int c = 0; c < NCH; c++) begin
                st.ch[c].crc_fail_threshold <= ring_mon_pkg::CRC_THR_RST;
                st.ch[c].crc_window_length <= ring_mon_pkg::CRC_WIN_RST;
                st.ch[c].lost_msg_threshold <= ring_mon_pkg::LOST_THR_RST;
                st.ch[c].lost_msg_window_length <= ring_mon_pkg::LOST_WIN_RST;
            end
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register
    assign rdata_o = st.rdata;
    assign tx_valid_o = st.tx_valid;
    assign tx_msg_o = st.tx_msg;
    assign relay_o = st.relay;
    assign unprog_o = st.unprog;
    assign ring_break_o = st.ring_break;
    assign irq_o = st.irq;
    for (genvar g = 0; g < NCH; g++) begin : g_out
        assign crc_rate_alarm_flag_o[g] = st.ch[g].crc.alarm;
        assign lost_msg_alarm_flag_o[g] = st.ch[g].lost.alarm;
    end

    // Checks: relay and self-test flag, then monitors on channel 0
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (srst_i);
    sequence s_bad_rx;
        rx_valid_i[0] && !crc_ok[0];
    endsequence
    sequence s_good_rx;
        rx_valid_i[0] && crc_ok[0];
    endsequence
    sequence s_win_end;
        rx_valid_i[0] && st.ch[0].crc_window_length != 16'h0000
            && st.ch[0].crc.tot + 16'h0001 >= st.ch[0].crc_window_length;
    endsequence
    a_relay_inhibit: assert property (
        !st.programmed |-> relay_o == 16'h0000)
        else $error("relay driven while unprogrammed");
    a_unprog_flag: assert property (unprog_o == !st.programmed)
        else $error("self-test flag does not track programmed state");
    a_rx_count: assert property (
        rx_valid_i[0] |=> st.ch[0].crc.tot == $past(st.ch[0].crc.tot)
            + 16'h0001 || st.ch[0].crc.tot == 16'h0000)
        else $error("received message not counted");
    a_fail_count: assert property (
        s_bad_rx |=> st.ch[0].crc.bad == $past(st.ch[0].crc.bad)
            + 16'h0001 || st.ch[0].crc.bad == 16'h0000)
        else $error("failed message not counted");
    a_good_nofail: assert property (
        s_good_rx |=> st.ch[0].crc.bad == $past(st.ch[0].crc.bad)
            || st.ch[0].crc.bad == 16'h0000)
        else $error("good message counted as failed");
    a_crc_alarm: assert property (
        $rose(crc_rate_alarm_flag_o[0])
            |-> st.ch[0].crc.bad >= st.ch[0].crc_fail_threshold)
        else $error("check alarm below threshold");
    a_window_clear: assert property (
        s_win_end |=> st.ch[0].crc.tot == 16'h0000
            && st.ch[0].crc.bad == 16'h0000 && !crc_rate_alarm_flag_o[0])
        else $error("window end did not clear monitor");
    a_fail_total: assert property (
        s_bad_rx |=> st.ch[0].crc_fail_total
            == $past(st.ch[0].crc_fail_total) + 16'h0001)
        else $error("failed total not incremented");
    a_forward: assert property (
        s_good_rx ##0 rx_msg_i[0].origin != st.own_id
            |=> tx_valid_o[0] && tx_msg_o[0] == $past(rx_msg_i[0]))
        else $error("foreign message not forwarded");
    a_ring_only: assert property (
        !st.ring_mode |=> !lost_msg_alarm_flag_o[0] && !st.ch[0].wait_ret)
        else $error("lost monitor active outside ring mode");
    a_ring_break: assert property (
        lost_ev[0] |=> ring_break_o)
        else $error("lost message did not raise ring break");
endmodule
`default_nettype wire

// >>> verif/ring_peer.sv
// Peer device model on the ring: sends foreign messages, echoes ours
`timescale 1ns/100ps
`default_nettype none
module ring_peer (
    input wire logic clk_i,
    input wire logic [7:0] id_i,
    input wire logic [1:0] echo_i,
    input wire logic [1:0] inj_i,
    input wire logic bad_i,
    input wire logic [1:0] txv_i,
    input wire ring_mon_pkg::msg_s [1:0] txm_i,
    output logic [1:0] rxv_o,
    output ring_mon_pkg::msg_s [1:0] rxm_o
);
    ring_mon_pkg::msg_s m;
    logic [31:0] c;
    initial rxv_o = '0;
    initial rxm_o = '0;
    // Idle lines invert so a stale message is never mistaken for new
    always @(posedge clk_i) begin
        for (int k = 0; k < 2; k++) begin
            if (inj_i[k]) begin
                m = {8'h33, 8'($urandom), 112'({$urandom, $urandom,
                    $urandom, $urandom}), 32'h0};
                c = 32'hffffffff;
                for (int b = 127; b >= 0; b--)
                    c = {c[30:0], 1'b0} ^ ((c[31] ^ m[b+32]) ?
                        32'h04c11db7 : 32'h0);
                m.crc = bad_i ? ~c : c;
                rxv_o[k] <= 1'b1;
                rxm_o[k] <= m;
            end else if (txv_i[k] && echo_i[k]
                && txm_i[k].origin == id_i) begin
                rxv_o[k] <= 1'b1;
                rxm_o[k] <= txm_i[k];
            end else begin
                rxv_o[k] <= 1'b0;
                rxm_o[k] <= ~rxm_o[k];
            end
        end
    end
endmodule
`default_nettype wire

// >>> verif/ring_link_integrity_monitor_tb_top.sv
// Self-checking bench of the ring link integrity monitor
`timescale 1ns/100ps
`default_nettype none
module ring_link_integrity_monitor_tb_top;
    localparam int P64 = 400;
    localparam int P128 = 200;
    localparam int RT = 40;
    localparam logic [7:0] ID = 8'h11; // Arbitrary station number
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] addr = '0;
    logic [31:0] wdata = '0;
    logic wen = 1'b0;
    logic ren = 1'b0;
    logic bad = 1'b0;
    logic [1:0] echo = '0;
    logic [1:0] inj = '0;
    logic [31:0] rdata, d, a, b;
    logic [1:0] rxv, txv, crc_al, lost_al;
    logic [15:0] relay;
    logic unprog, brk, irq;
    ring_mon_pkg::msg_s [1:0] rxm, txm;
    int n_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    int t;
    int tot[2] = '{0, 0};
    int bad_n[2] = '{0, 0};
    int ftot[2] = '{0, 0};
    // Clock and free-running cycle count
    always #2.5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    ring_link_integrity_monitor #(.INTEG_CYC_64(P64), .INTEG_CYC_128(P128),
        .RET_CYC(RT)) DUT (.core_clk_i(clk), .srst_i(srst), .addr_i(addr),
        .wdata_i(wdata), .wen_i(wen), .ren_i(ren), .rdata_o(rdata),
        .rx_valid_i(rxv), .rx_msg_i(rxm), .tx_valid_o(txv), .tx_msg_o(txm),
        .relay_o(relay), .unprog_o(unprog), .ring_break_o(brk),
        .crc_rate_alarm_flag_o(crc_al), .lost_msg_alarm_flag_o(lost_al),
        .irq_o(irq));
    ring_peer peer (.clk_i(clk), .id_i(ID), .echo_i(echo), .inj_i(inj),
        .bad_i(bad), .txv_i(txv), .txm_i(txm), .rxv_o(rxv), .rxm_o(rxm));
    // Ends the run with counts and verdict
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask
    // Register bus: one-cycle strobes, read data the cycle after
    task automatic wr(logic [7:0] ad, logic [31:0] dt);
        @(posedge clk);
        addr <= ad;
        wdata <= dt;
        wen <= 1'b1;
        @(posedge clk);
        wen <= 1'b0;
    endtask
    task automatic rd(logic [7:0] ad, output logic [31:0] dt);
        @(posedge clk);
        addr <= ad;
        ren <= 1'b1;
        @(posedge clk);
        ren <= 1'b0;
        #1 dt = rdata;
    endtask
    // Waits for a message of our own origin on channel 0
    task automatic wait_orig(int lim);
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (!(txv[0] === 1'b1 && txm[0].origin === ID) && k < lim);
        if (!(txv[0] === 1'b1 && txm[0].origin === ID)) begin
            n_errors++;
            give_verdict();
        end
    endtask
    // One foreign message from the peer, then model and compare
    task automatic send(int c, logic bb);
        ring_mon_pkg::msg_s m;
        logic f;
        @(posedge clk);
        bad <= bb;
        inj[c] <= 1'b1;
        @(posedge clk);
        inj[c] <= 1'b0;
        #1 m = rxm[c];
        f = 1'b0;
        repeat (4) begin
            @(posedge clk);
            if (txv[c] === 1'b1 && txm[c] === m)
                f = 1'b1;
        end
        chk("forward", f, !bb);
        tot[c]++;
        bad_n[c] += bb;
        ftot[c] += bb;
        if (tot[c] == 8) begin
            tot[c] = 0;
            bad_n[c] = 0;
        end
        chk("crc_alarm", crc_al, {bad_n[1] >= 3, bad_n[0] >= 3});
        rd(8'h48 + 8'(c * 32), d);
        chk("crc_win", d, {16'(bad_n[c]), 16'(tot[c])});
        rd(8'h50 + 8'(c * 32), d);
        chk("crc_total", d, ftot[c]);
    endtask
    // Main sequence
    initial begin
        void'($urandom(32'h68d1));
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        #1 chk("unprog", unprog, 1);
        rd(8'h40, d);
        chk("crc_cfg", d, 32'h04b0000a);
        rd(8'hfc, d);
        chk("unmapped", d, 0);
        wr(8'h04, 32'h5a5a);
        repeat (3) @(posedge clk);
        chk("relay_off", relay, 0);
        wr(8'h00, {16'h0, ID, 8'h01});
        repeat (3) @(posedge clk);
        chk("relay_on", relay, 32'h5a5a);
        chk("unprog", unprog, 0);
        $display("test setup done");
        for (int c = 0; c < 2; c++) begin
            wr(8'h40 + 8'(c * 32), 32'h00080003);
            for (int i = 0; i < 12; i++)
                send(c, 1'($urandom));
        end
        $display("test crc done");
        wait_orig(1000);
        t = cyc;
        wait_orig(1000);
        chk("gap64", (cyc - t - P64) inside {[-2:2]}, 1);
        wr(8'h00, {16'h0, ID, 8'h05});
        wait_orig(1000);
        wait_orig(1000);
        t = cyc;
        wait_orig(1000);
        chk("gap128", (cyc - t - P128) inside {[-2:2]}, 1);
        $display("test rate done");
        wr(8'h44, 32'h00640001);
        wr(8'h64, 32'h00640001);
        wr(8'h00, {16'h0, ID, 8'h03});
        wait_orig(1000);
        repeat (RT + 5) @(posedge clk);
        rd(8'h54, a);
        wr(8'h04, 32'h00ff);
        wait_orig(20);
        repeat (RT + 5) @(posedge clk);
        rd(8'h54, b);
        chk("lost_total", b, a + 1);
        chk("ring_break", brk, 1);
        chk("lost_alarm", lost_al, 2'b11);
        rd(8'h08, d);
        chk("stat", d[5:0], {4'b0111, bad_n[1] >= 3, bad_n[0] >= 3});
        rd(8'h0c, d);
        chk("irq_stat", d[2], 1);
        chk("irq_masked", irq, 0);
        echo <= 2'b11;
        wr(8'h10, 32'h4);
        repeat (2) @(posedge clk);
        chk("irq_on", irq, 1);
        wr(8'h0c, 32'h1f);
        repeat (2) @(posedge clk);
        chk("irq_clear", irq, 0);
        wr(8'h04, 32'h0f0f);
        repeat (RT + 5) @(posedge clk);
        rd(8'h54, d);
        chk("returned", d, b);
        chk("ring_ok", brk, 0);
        echo <= 2'b00;
        wr(8'h00, {16'h0, ID, 8'h01});
        wr(8'h04, 32'h00f0);
        repeat (RT + 5) @(posedge clk);
        rd(8'h54, d);
        chk("no_ring", d, b);
        chk("no_break", brk, 0);
        $display("test ring done");
        give_verdict();
    end
endmodule
`default_nettype wire
